// [hw/mur_ctrl_regs.sv]
// Control register bank: serial link, divider, audio swap, host transfer mode
`timescale 1ns/1ps
module mur_ctrl_regs
   import mur_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic [17:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   output logic WB_ACK_O,
   input wire logic SYNTH_LOCKED,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_PARITY,
   input wire logic [7:0] Q_IN,
   output logic [7:0] Q_OUT,
   input wire logic [7:0] SUBC_IN,
   output logic [7:0] SUBC_OUT,
   input wire logic SRC_TICK,
   input wire logic EXT_SER_CLK,
   output logic SER_CLK_OUT,
   output logic SER_SAMPLE_CLK,
   input wire logic AUDIO_MODE,
   input wire logic [15:0] AUD_WORD_IN,
   output logic [15:0] BUF_WORD_OUT,
   input wire logic SUBC_BIT_TICK,
   output logic SUBC_SAMPLE_EN,
   input wire logic TEST_PIN,
   output logic TEST_MUX_EN,
   output logic [3:0] TEST_OUT,
   output logic BAUD_TICK,
   output logic EVEN_PARITY,
   output logic DOUBLER_EN,
   output logic DRAM_PAGE_MODE,
   output logic BUF_WRITE,
   output logic START_SET_B,
   output logic END_SET_B,
   output logic DUAL_SET
);

   function automatic logic hit(input logic [17:0] adr,
                                input logic [15:0] ofs);
      hit = (adr[17:2] == ofs);
   endfunction

   // Reserved code 11 falls back to the slowest rate
   function automatic logic [11:0] baud_period(input logic [1:0] sel);
      unique case (sel)
         BAUD_MID: baud_period = BAUD_MID_CYC;
         BAUD_FAST: baud_period = BAUD_FAST_CYC;
         default: baud_period = BAUD_SLOW_CYC;
      endcase
   endfunction

   logic [7:0] baud_reg;
   logic [7:0] div_reg;
   logic [7:0] aud_reg;
   logic [7:0] host_reg;
   logic par_err;
   logic lock_q;
   logic [11:0] baud_cnt;
   logic [5:0] div_cnt;
   logic int_clk;
   logic [1:0] ovs_cnt;

   // Bus decode
   wire req = WB_CYC_I & WB_STB_I;
   wire wr = req & WB_ACK_O & WB_WE_I & WB_SEL_I[0];
   wire wr_baud = wr & hit(WB_ADR_I, OFS_BAUD);
   wire wr_div = wr & hit(WB_ADR_I, OFS_DIV);
   wire wr_aud = wr & hit(WB_ADR_I, OFS_AUD);
   wire wr_host = wr & hit(WB_ADR_I, OFS_HOST);
   wire wr_stat = wr & hit(WB_ADR_I, OFS_STAT);
   wire [7:0] wd = WB_DAT_I[7:0];
   wire [7:0] baud_rd = (baud_reg & BAUD_WMASK)
                        | ({7'h00, lock_q} << B_LOCK);
   wire [7:0] stat_rd = {7'h00, par_err};
   wire [7:0] rd_byte =
      hit(WB_ADR_I, OFS_BAUD) ? baud_rd :
      hit(WB_ADR_I, OFS_DIV) ? div_reg :
      hit(WB_ADR_I, OFS_AUD) ? (aud_reg & AUD_WMASK) :
      hit(WB_ADR_I, OFS_HOST) ? (host_reg & HOST_WMASK) :
      hit(WB_ADR_I, OFS_STAT) ? stat_rd : RESET_VAL;

   // Parity: a frame is good when data plus parity bit is even for even
   // mode and odd for odd mode
   wire rx_ones = ^{RX_DATA, RX_PARITY};
   wire rx_bad = RX_VALID & (rx_ones == baud_reg[B_EVEN]);

   wire [11:0] baud_last = baud_period(baud_reg[1:0]) - 12'h001;
   wire [6:0] div_period = DIV_BASE - {1'b0, div_reg[5:0]};
   wire [6:0] div_last = div_period - 7'h01;
   wire [6:0] div_half = div_period >> 1;
   wire div_run = div_reg[D_SRC] | div_reg[D_SMP];
   wire next_int_clk = ({1'b0, div_cnt} < div_half);
   wire [15:0] swapped = {AUD_WORD_IN[7:0], AUD_WORD_IN[15:8]};
   wire do_swap = AUDIO_MODE & ~aud_reg[A_BSB];
   wire test_on = aud_reg[A_TEST] & TEST_PIN;

   // Wishbone slave: one wait state, ack for one cycle, zero on unmapped
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= req & ~WB_ACK_O;
         WB_DAT_O <= {24'h00_0000, rd_byte};
      end
   end

   // Registers; writes land on the acknowledged edge and drive outputs next
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         baud_reg <= RESET_VAL;
         div_reg <= RESET_VAL;
         aud_reg <= RESET_VAL;
         host_reg <= RESET_VAL;
         lock_q <= 1'b0;
      end else begin
         lock_q <= SYNTH_LOCKED;
         if (wr_baud) baud_reg <= wd & BAUD_WMASK;
         if (wr_div) div_reg <= wd & DIV_WMASK;
         if (wr_aud) aud_reg <= wd & AUD_WMASK;
         if (wr_host) host_reg <= wd & HOST_WMASK;
      end
   end

   // Sticky parity error, write one to clear; a new error wins the clear
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) par_err <= 1'b0;
      else if (rx_bad) par_err <= 1'b1;
      else if (wr_stat & wd[S_PERR]) par_err <= 1'b0;
   end

   // Baud tick generator
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         baud_cnt <= 12'h000;
         BAUD_TICK <= 1'b0;
      end else if (baud_cnt >= baud_last) begin
         baud_cnt <= 12'h000;
         BAUD_TICK <= 1'b1;
      end else begin
         baud_cnt <= baud_cnt + 12'h001;
         BAUD_TICK <= 1'b0;
      end
   end

   // Internal serial clock from the source tick; held idle when unused
   always_ff @(posedge REF_CLK) begin
      if (!RST_B || !div_run) begin
         div_cnt <= 6'h00;
         int_clk <= 1'b0;
      end else if (SRC_TICK) begin
         if ({1'b0, div_cnt} >= div_last) div_cnt <= 6'h00;
         else div_cnt <= div_cnt + 6'h01;
         int_clk <= next_int_clk;
      end
   end

   // Sub-code sampling strobe, quarter rate when oversampling
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         ovs_cnt <= 2'h0;
         SUBC_SAMPLE_EN <= 1'b0;
      end else begin
         if (SUBC_BIT_TICK) ovs_cnt <= ovs_cnt + 2'h1;
         SUBC_SAMPLE_EN <= SUBC_BIT_TICK
            & (~aud_reg[A_OVS] | (ovs_cnt == OVS_LAST));
      end
   end

   // Data path and control outputs, all registered
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         Q_OUT <= 8'h00;
         SUBC_OUT <= 8'h00;
         BUF_WORD_OUT <= 16'h0000;
         SER_CLK_OUT <= 1'b0;
         SER_SAMPLE_CLK <= 1'b0;
         TEST_MUX_EN <= 1'b0;
         TEST_OUT <= 4'h0;
         EVEN_PARITY <= 1'b0;
         DOUBLER_EN <= 1'b0;
      end else begin
         Q_OUT <= Q_IN ^ {8{baud_reg[B_QINV]}};
         SUBC_OUT <= SUBC_IN ^ {8{baud_reg[B_SUBI]}};
         BUF_WORD_OUT <= do_swap ? swapped : AUD_WORD_IN;
         SER_CLK_OUT <= div_reg[D_SRC] ? int_clk : EXT_SER_CLK;
         SER_SAMPLE_CLK <= div_reg[D_SMP] ? int_clk : EXT_SER_CLK;
         TEST_MUX_EN <= test_on;
         TEST_OUT <= test_on ? {int_clk, BAUD_TICK, par_err, lock_q} : 4'h0;
         EVEN_PARITY <= baud_reg[B_EVEN];
         // Firmware waits for the stable flag; no interlock here
         DOUBLER_EN <= baud_reg[B_DBL];
      end
   end

   // Host transfer mode: decoded straight from the register
   always_comb begin
      DRAM_PAGE_MODE = host_reg[H_PAGE];
      BUF_WRITE = host_reg[H_WR];
      START_SET_B = host_reg[H_STR];
      END_SET_B = host_reg[H_END];
      DUAL_SET = host_reg[H_DUAL];
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);

   chk_baud_wrap:
   assert property ((baud_cnt == baud_last && $past(RST_B))
                    |=> BAUD_TICK && baud_cnt == 12'h000)
      else $error("baud tick missing at period end");

   chk_q_invert:
   assert property ($past(RST_B) |=>
                    Q_OUT == ($past(Q_IN) ^ {8{$past(baud_reg[B_QINV])}}))
      else $error("Q-channel output wrong");

   chk_subc_invert:
   assert property ($past(RST_B) |=>
                    SUBC_OUT == ($past(SUBC_IN)
                                 ^ {8{$past(baud_reg[B_SUBI])}}))
      else $error("sub-code output wrong");

   chk_parity_flag:
   assert property (rx_bad |=> par_err)
      else $error("parity error not flagged");

   chk_lock_read:
   assert property ((req && !WB_ACK_O && hit(WB_ADR_I, OFS_BAUD))
                    |=> WB_DAT_O[B_LOCK] == $past(lock_q))
      else $error("stable flag readback wrong");

   chk_doubler_follow:
   assert property ($rose(baud_reg[B_DBL]) |=> DOUBLER_EN)
      else $error("doubler not engaged");

   chk_ext_clock:
   assert property ((!div_reg[D_SRC] && $past(RST_B))
                    |=> SER_CLK_OUT == $past(EXT_SER_CLK))
      else $error("serial clock not from pin");

   chk_byte_swap:
   assert property ((do_swap && $past(RST_B))
                    |=> BUF_WORD_OUT == $past(swapped))
      else $error("audio word not swapped");

   chk_host_write:
   assert property (wr_host |=> DRAM_PAGE_MODE == $past(wd[H_PAGE])
                    && BUF_WRITE == $past(wd[H_WR]))
      else $error("host mode write not applied");

   chk_test_mux:
   assert property (TEST_MUX_EN |-> $past(test_on))
      else $error("test mux enabled without cause");

   chk_ack_single:
   assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held longer than one cycle");

   chk_ack_answer:
   assert property ((req && !WB_ACK_O) |=> WB_ACK_O)
      else $error("request not acknowledged");

   chk_baud_quiet:
   assert property ((baud_cnt < baud_last) |=> !BAUD_TICK)
      else $error("baud tick before period end");

   chk_baud_reserved:
   assert property ((baud_reg[1:0] == 2'h3
                     && baud_cnt == BAUD_SLOW_CYC - 12'h001)
                    |=> BAUD_TICK)
      else $error("reserved baud code not at slowest rate");

   chk_even_parity:
   assert property ($past(RST_B) |=>
                    EVEN_PARITY == $past(baud_reg[B_EVEN]))
      else $error("parity select output wrong");

   chk_perr_hold:
   assert property ((par_err && !(wr_stat && wd[S_PERR])) |=> par_err)
      else $error("parity error flag lost");

   chk_perr_clear:
   assert property ((wr_stat && wd[S_PERR] && !rx_bad) |=> !par_err)
      else $error("parity error flag not cleared");

   chk_lock_readonly:
   assert property (wr_baud |=> !baud_reg[B_LOCK])
      else $error("stable bit stored by a write");

   chk_doubler_off:
   assert property ($fell(baud_reg[B_DBL]) |=> !DOUBLER_EN)
      else $error("doubler not released");

   chk_div_wrap:
   assert property ((div_run && SRC_TICK && {1'b0, div_cnt} == div_last)
                    |=> div_cnt == 6'h00)
      else $error("divider did not wrap");

   chk_div_hold:
   assert property ((div_run && !SRC_TICK) |=> $stable(div_cnt))
      else $error("divider moved without source tick");

   chk_sample_int:
   assert property ((div_reg[D_SMP] && $past(RST_B))
                    |=> SER_SAMPLE_CLK == $past(int_clk))
      else $error("sample clock not from counter");

   chk_sample_ext:
   assert property ((!div_reg[D_SMP] && $past(RST_B))
                    |=> SER_SAMPLE_CLK == $past(EXT_SER_CLK))
      else $error("sample clock not from pin");

   chk_int_clock:
   assert property ((div_reg[D_SRC] && $past(RST_B))
                    |=> SER_CLK_OUT == $past(int_clk))
      else $error("serial clock not from counter");

   chk_int_idle:
   assert property (!div_run |=> !int_clk && div_cnt == 6'h00)
      else $error("internal clock runs while unused");

   chk_no_swap:
   assert property ((!do_swap && $past(RST_B))
                    |=> BUF_WORD_OUT == $past(AUD_WORD_IN))
      else $error("audio word swapped unexpectedly");

   chk_ovs_off:
   assert property ((!aud_reg[A_OVS] && $past(RST_B))
                    |=> SUBC_SAMPLE_EN == $past(SUBC_BIT_TICK))
      else $error("sub-code strobe not at full rate");

   chk_ovs_quarter:
   assert property ((aud_reg[A_OVS] && SUBC_BIT_TICK && ovs_cnt != OVS_LAST)
                    |=> !SUBC_SAMPLE_EN)
      else $error("sub-code strobe not at quarter rate");

   chk_test_off:
   assert property (!test_on |=> !TEST_MUX_EN && TEST_OUT == 4'h0)
      else $error("test outputs active without cause");

   chk_host_start:
   assert property (wr_host |=> START_SET_B == $past(wd[H_STR]))
      else $error("start offset set select wrong");

   chk_host_end:
   assert property (wr_host |=> END_SET_B == $past(wd[H_END]))
      else $error("end offset set select wrong");

   chk_host_dual:
   assert property (wr_host |=> DUAL_SET == $past(wd[H_DUAL]))
      else $error("dual set select wrong");

   chk_host_stable:
   assert property (!wr_host |=> $stable(host_reg))
      else $error("host mode changed without a write");

   chk_aud_reserved:
   assert property (wr_aud |=> (aud_reg & ~AUD_WMASK) == 8'h00)
      else $error("reserved audio bits stored");

   chk_host_reserved:
   assert property (wr_host |=> (host_reg & ~HOST_WMASK) == 8'h00)
      else $error("reserved host bits stored");

endmodule // mur_ctrl_regs

// [hw/mur_pkg.sv]
// Constants and register layout for the serial, audio and host control bank
// Operation
// - Baud field picks 31.25, 62.5 or 187.5 kbaud; code 11 undefined.
// - Q-channel invert bit inverts every passed Q-channel bit when set.
// - Sub-code invert bit inverts all passed sub-code bits when set.
// - Parity select bit gives even parity when set, odd when clear.
// - Stable bit is read-only and reads high once the synthesizer settles.
// - Firmware enables doubler only after stable; doubler follows enable bit.
// - Serial-port clock can be divided down from the 16.945 MHz source.
// - Six-bit divisor: 0 gives about 0.264 MHz, 58 about 2.82 MHz.
// - Sample-source bit: 0 samples on external clock, 1 on internal counter.
// - Clock-source bit: 0 uses pin and stops internal, 1 uses counter; internal counter still runs while sample-source bit is 1.
// - Audio byte swap unless swap bit high, then stored like data mode.
// - Oversample bit high samples sub-code inputs at a quarter rate.
// - Test bit plus high test pin routes internal signals to test outputs.
// - Host transfer mode writes act at once on DRAM access control.
// - Access-type bit: 0 byte access, 1 page-mode access.
// - Direction bit: 0 reads buffer, 1 writes buffer.
// - Start-offset bit: 0 selects A set, 1 selects B set.
// - End-offset bit: 0 selects A set, 1 selects B set.
// - Dual-set bit: 0 only A offsets, 1 both A and B offsets.
// - Baud/invert register at F0C0 with fields in documented bit positions.
// - Parity error flag sets on a parity mismatch in a received byte.
package mur_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] OFS_DIV = 16'hf09e;
   localparam logic [15:0] OFS_BAUD = 16'hf0c0;
   localparam logic [15:0] OFS_AUD = 16'hf0c1;
   localparam logic [15:0] OFS_STAT = 16'hf0c4;
   localparam logic [15:0] OFS_HOST = 16'hf0fd;
   localparam logic [7:0] RESET_VAL = 8'h00;
   localparam logic [7:0] BAUD_WMASK = 8'hbb;
   localparam logic [7:0] AUD_WMASK = 8'h8c;
   localparam logic [7:0] HOST_WMASK = 8'h1f;
   localparam logic [7:0] DIV_WMASK = 8'hff;
   // Baud/invert/doubler fields
   localparam int B_DBL = 7;
   localparam int B_LOCK = 6;
   localparam int B_EVEN = 5;
   localparam int B_SUBI = 4;
   localparam int B_QINV = 3;
   // Divider fields
   localparam int D_SRC = 7;
   localparam int D_SMP = 6;
   // Audio/test fields
   localparam int A_TEST = 7;
   localparam int A_OVS = 3;
   localparam int A_BSB = 2;
   // Host transfer mode fields
   localparam int H_PAGE = 0;
   localparam int H_WR = 1;
   localparam int H_STR = 2;
   localparam int H_END = 3;
   localparam int H_DUAL = 4;
   // Status fields
   localparam int S_PERR = 0;
   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int BAUD_SLOW_HZ = 31_250;
   localparam int BAUD_MID_HZ = 62_500;
   localparam int BAUD_FAST_HZ = 187_500;
   localparam logic [11:0] BAUD_SLOW_CYC = 12'(CLK_HZ / BAUD_SLOW_HZ);
   localparam logic [11:0] BAUD_MID_CYC = 12'(CLK_HZ / BAUD_MID_HZ);
   localparam logic [11:0] BAUD_FAST_CYC = 12'(CLK_HZ / BAUD_FAST_HZ);
   localparam logic [1:0] BAUD_SLOW = 2'h0;
   localparam logic [1:0] BAUD_MID = 2'h1;
   localparam logic [1:0] BAUD_FAST = 2'h2;
   // Serial clock period in source ticks is DIV_BASE minus divisor
   localparam logic [6:0] DIV_BASE = 7'h40;
   localparam logic [1:0] OVS_LAST = 2'h3;
endpackage

// [verification/mur_ctrl_regs_tb.sv]
// Self-checking bench for the control register bank
`timescale 1ns/1ps
module mur_ctrl_regs_tb;
   import mur_pkg::*;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
   logic clk = 0, rst_b = 0, we, cyc, stb, ack, lock = 0, rxv = 0;
   logic rxp = 0, stick = 0, ext = 0, am = 0, sbt = 0, tpin = 0;
   logic sco, ssc, sse, tme, bt, evp, dbl, pg, bw, ss, es, ds;
   logic [17:0] adr;
   logic [31:0] wdat, rdat, q;
   logic [3:0] sel, tout;
   logic [7:0] rxd = 0, qi = 0, si = 0, qo, so;
   logic [15:0] awi = 0, bwo;
   int miscompares = 0, n_tests = 0, n, sen = 0;
   always #5 clk = ~clk;
   always @(posedge clk) stick <= ~stick;
   always @(posedge clk) sen <= sen + int'(sse === 1'b1);
   mur_mcu_model mcu (.clk(clk), .adr(adr), .dat(wdat), .we(we), .sel(sel),
      .cyc(cyc), .stb(stb), .ack(ack), .rdat(rdat));
   mur_ctrl_regs dut (.REF_CLK(clk), .RST_B(rst_b), .WB_ADR_I(adr),
      .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(sel),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack), .SYNTH_LOCKED(lock),
      .RX_VALID(rxv), .RX_DATA(rxd), .RX_PARITY(rxp), .Q_IN(qi), .Q_OUT(qo),
      .SUBC_IN(si), .SUBC_OUT(so), .SRC_TICK(stick), .EXT_SER_CLK(ext),
      .SER_CLK_OUT(sco), .SER_SAMPLE_CLK(ssc), .AUDIO_MODE(am),
      .AUD_WORD_IN(awi), .BUF_WORD_OUT(bwo), .SUBC_BIT_TICK(sbt),
      .SUBC_SAMPLE_EN(sse), .TEST_PIN(tpin), .TEST_MUX_EN(tme),
      .TEST_OUT(tout), .BAUD_TICK(bt), .EVEN_PARITY(evp), .DOUBLER_EN(dbl),
      .DRAM_PAGE_MODE(pg), .BUF_WRITE(bw), .START_SET_B(ss),
      .END_SET_B(es), .DUAL_SET(ds));
   task automatic wr(input logic [15:0] o, input logic [7:0] d,
      input logic [3:0] s = 4'h1);
      mcu.xfer(1'b1, o, d, s, q);
   endtask
   task automatic rd_chk(input logic [15:0] o, input logic [7:0] e);
      mcu.xfer(1'b0, o, 8'h00, 4'hf, q);
      `CHK(q, {24'h0, e})
   endtask
   task automatic rx(input logic bad, input logic ev);
      logic [7:0] d = $urandom;
      @(posedge clk);
      rxd <= d;
      rxp <= ^d ^ ~ev ^ bad;
      rxv <= 1'b1;
      @(posedge clk);
      rxv <= 1'b0;
      rxd <= ~d;
   endtask
   function automatic int baud_cyc(input logic [1:0] c);
      return c == 2'h1 ? 100_000_000 / 62_500 :
         c == 2'h2 ? 100_000_000 / 187_500 : 100_000_000 / 31_250;
   endfunction
   task automatic summarize();
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge clk);
      miscompares++;
      summarize();
   end
   initial begin
      logic [15:0] ofs [4] = '{OFS_DIV, OFS_BAUD, OFS_AUD, OFS_HOST};
      logic [7:0] msk [4] = '{DIV_WMASK, BAUD_WMASK, AUD_WMASK, HOST_WMASK};
      logic [7:0] v;
      logic [15:0] w;
      void'($urandom(32'h1f6dee0e));
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 4; i++) rd_chk(ofs[i], 8'h00);
      rd_chk(16'hf0c2, 8'h00);
      lock <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         if (i == 0) v &= 8'hcf;
         if (i == 1) v[7] = 1'b1;
         wr(ofs[i], v);
         wr(ofs[i], ~v, 4'he);
         w = {8'h0, v & msk[i]} | (i == 1 ? 16'h40 : 16'h0);
         rd_chk(ofs[i], w[7:0]);
         if (i == 1) `CHK({dbl, evp}, {v[7], v[5]})
      end
      for (int i = 0; i < 5; i++) begin
         wr(OFS_HOST, 8'h1 << i);
         @(negedge clk);
         `CHK({ds, es, ss, bw, pg}, 5'h1 << i)
         `CHK({ds, es}, 2'(5'h1 << i >> 3))
      end
      for (int i = 0; i < 4; i++) begin
         wr(OFS_BAUD, {3'b0, i[1:0], 3'b0});
         repeat (2) @(posedge clk);
         qi <= $urandom;
         si <= $urandom;
         @(posedge clk);
         @(negedge clk);
         `CHK(qo, qi ^ {8{i[0]}})
         `CHK(so, si ^ {8{i[1]}})
      end
      for (int e = 0; e < 2; e++) begin
         wr(OFS_BAUD, e[0] ? 8'h20 : 8'h00);
         for (int b = 0; b < 2; b++) begin
            wr(OFS_STAT, 8'h01);
            rx(b[0], e[0]);
            rd_chk(OFS_STAT, {7'h0, b[0]});
         end
      end
      for (int i = 0; i < 4; i++) begin
         // Test bit rides along with the swap bit
         wr(OFS_AUD, i[1] ? 8'h84 : 8'h00);
         am <= i[0];
         tpin <= i[0];
         w = $urandom;
         awi <= w;
         repeat (2) @(posedge clk);
         @(negedge clk);
         `CHK(bwo, i == 1 ? {w[7:0], w[15:8]} : w)
         `CHK(tme, i == 3)
         // Stable flag and the sticky parity error are both set here
         `CHK(tout & 4'h3, i == 3 ? 4'h3 : 4'h0)
      end
      for (int i = 0; i < 2; i++) begin
         wr(OFS_AUD, i[0] ? 8'h08 : 8'h00);
         @(negedge clk);
         n = sen;
         repeat (8) begin
            @(posedge clk) sbt <= 1'b1;
            @(posedge clk) sbt <= 1'b0;
         end
         repeat (3) @(posedge clk);
         @(negedge clk);
         `CHK(sen - n, i ? 2 : 8)
      end
      wr(OFS_DIV, 8'h0f);
      repeat (10) begin
         @(posedge clk) ext <= $urandom;
         @(posedge clk);
         @(negedge clk);
         `CHK({sco, ssc}, {ext, ext})
      end
      for (int j = 0; j < 2; j++) begin
         wr(OFS_DIV, j ? 8'h4f : 8'h8f);
         n = 0;
         repeat (400) begin
            v[1:0] = {sco, ssc};
            @(negedge clk);
            n += int'({sco, ssc} != v[1:0]);
         end
         // Divisor 15 gives a period near 98 cycles here
         `CHK(n > 5, 1'b1)
         `CHK(j ? sco : ssc, ext)
      end
      for (int c = 0; c < 4; c++) begin
         wr(OFS_BAUD, 8'(c));
         repeat (2) begin
            do @(posedge clk); while (bt !== 1'b1);
         end
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (bt !== 1'b1);
         `CHK(n, baud_cyc(c[1:0]))
      end
      summarize();
   end
endmodule // mur_ctrl_regs_tb

// [verification/mur_mcu_model.sv]
// Microcontroller side of the register bus: classic single-cycle master
`timescale 1ns/1ps
module mur_mcu_model
   import mur_pkg::*;
(
   input wire logic clk,
   output logic [17:0] adr,
   output logic [31:0] dat,
   output logic we,
   output logic [3:0] sel,
   output logic cyc,
   output logic stb,
   input wire logic ack,
   input wire logic [31:0] rdat
);
   initial begin
      {adr, dat, we, sel, cyc, stb} = '0;
   end
   // Waits on ack without limit; the bench watchdog ends a hang
   task automatic xfer(input logic w, input logic [15:0] o,
      input logic [7:0] d, input logic [3:0] s, output logic [31:0] q);
      @(posedge clk);
      adr <= {o, 2'b00};
      dat <= {24'h0, d};
      we <= w;
      sel <= s;
      {cyc, stb} <= 2'b11;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      {cyc, stb, we} <= 3'b000;
      // Released data does not keep its last value
      dat <= ~{24'h0, d};
   endtask
endmodule // mur_mcu_model
